// ### verilog/offset_comp_step_count_regs.sv
// offset_comp_step_count_regs: offset compensation bytes, step total and
// step detector configuration, plus the offset adders on the data paths.
// assumes a synchronous byte register port from the host interface, an
// nvm controller answering load/store requests, and the foc engine and
// step detector delivering one-cycle strobes on the same clock.
`timescale 1ns/1ps

// Overview of operation
// R1 - add offsets to data only when enabled
// R2 - offsets are signed two's complement values
// R3 - reload offsets from nvm after reset
// R4 - offsets can be stored into nvm
// R5 - host writes and foc results overwrite offsets
// R6 - accel offset eight bits signed, 3.9 mg
// R7 - gyro offset ten bits signed, 0.061 dps
// R8 - accel bytes 0-2, gyro low bytes 3-5
// R9 - byte 6 holds enables and gyro high bits
// R10 - sixteen bit read-only step total, reset zero
// R11 - two config bytes, bit 7 write-only
// R12 - host picks one of three configurations
// R13 - command 0xb2 clears the step total
// R14 - command 0xa0 stores offsets into nvm
// R15 - command 0x03 starts foc, stores results
module offset_comp_step_count_regs (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  // soft reset request from the command decoder
  input  wire logic        i_soft_rst,
  // nvm image of the seven offset bytes
  input  wire logic [55:0] i_nvm_data,
  input  wire logic        i_nvm_valid,
  output logic             o_nvm_load,
  output logic             o_nvm_store,
  output logic      [55:0] o_nvm_data,
  // foc engine
  output logic             o_foc_start,
  input  wire logic        i_foc_done,
  input  wire logic [7:0]  i_foc_acc_x,
  input  wire logic [7:0]  i_foc_acc_y,
  input  wire logic [7:0]  i_foc_acc_z,
  input  wire logic [9:0]  i_foc_gyr_x,
  input  wire logic [9:0]  i_foc_gyr_y,
  input  wire logic [9:0]  i_foc_gyr_z,
  // step detector
  input  wire logic        i_step,
  output logic      [15:0] o_step_conf,
  // data paths: three accel axes then three gyro axes, 16 bits each
  input  wire logic [95:0] i_filt_data,
  input  wire logic [95:0] i_pre_data,
  output logic      [95:0] o_filt_data,
  output logic      [95:0] o_pre_data
);

  // ==========================================================================
  // load sequencer states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,   // waiting for the nvm image
    ST_RUN  = 3'b010,   // normal operation
    ST_REQ  = 3'b100    // load request issued after soft reset
  } load_state_t;

  load_state_t state;          // current sequencer state
  load_state_t next_state;     // next sequencer state
  logic [7:0]  off [7];        // the seven offset bytes, by index
  logic [7:0]  next_off [7];
  logic [15:0] step;           // step total
  logic [15:0] next_step;
  logic [15:0] conf;           // step detector configuration
  logic [15:0] next_conf;
  logic [7:0]  rdata;          // registered read data
  logic [7:0]  next_rdata;
  logic        load_req;       // registered nvm load request
  logic        next_load_req;
  logic        store_req;      // registered nvm store strobe
  logic        next_store_req;
  logic        foc_req;        // registered foc start strobe
  logic        next_foc_req;
  logic        cmd_wr;         // host write to the command address
  logic [95:0] filt_q;         // registered compensated data
  logic [95:0] pre_q;
  logic [95:0] next_filt;
  logic [95:0] next_pre;
  logic [15:0] offs_ext [6];   // sign-extended offsets per axis
  logic        acc_en;
  logic        gyr_en;

  assign cmd_wr = i_wr && (i_addr == offset_step_pkg::ADDR_CMD);
  assign acc_en = off[6][offset_step_pkg::BIT_ACC_EN];
  assign gyr_en = off[6][offset_step_pkg::BIT_GYR_EN];

  // ==========================================================================
  // offset sign extension, one per axis
  // accel uses 8 signed bits regardless of range; gyro 10 signed bits
  // split over the low byte and two bits of byte 6
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ext
      assign offs_ext[g] = {{8{off[g][7]}}, off[g]};          // R2 R6 R8
      assign offs_ext[g+3] = {{6{off[6][2*g+1]}},
                              off[6][2*g +: 2], off[g+3]};    // R7 R9
    end
  endgenerate

  // ==========================================================================
  // load sequencer: offsets come back from nvm after por and soft reset
  always_comb begin
    next_state    = state;
    next_load_req = 1'b0;
    unique case (state)
      ST_LOAD: begin
        next_load_req = 1'b1;                                 // R3
        if (i_nvm_valid) begin
          next_state    = ST_RUN;
          next_load_req = 1'b0;
        end
      end
      ST_RUN: begin
        if (i_soft_rst) begin
          next_state = ST_REQ;                                // R3
        end
      end
      ST_REQ: begin
        next_state    = ST_LOAD;
        next_load_req = 1'b1;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= ST_LOAD;
      load_req <= 1'b0;
    end else begin
      state    <= next_state;
      load_req <= next_load_req;
    end
  end

  // ==========================================================================
  // offset bytes: nvm restore beats foc result beats host write
  always_comb begin
    for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
      next_off[i] = off[i];
    end
    if (state == ST_LOAD && i_nvm_valid) begin
      for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
        next_off[i] = i_nvm_data[8*i +: 8];                   // R3
      end
    end else if (i_foc_done) begin
      // foc overwrites values, leaves enables as set by the host
      next_off[0] = i_foc_acc_x;                              // R5 R15
      next_off[1] = i_foc_acc_y;
      next_off[2] = i_foc_acc_z;
      next_off[3] = i_foc_gyr_x[7:0];
      next_off[4] = i_foc_gyr_y[7:0];
      next_off[5] = i_foc_gyr_z[7:0];
      next_off[6] = {off[6][7:6], i_foc_gyr_z[9:8],
                     i_foc_gyr_y[9:8], i_foc_gyr_x[9:8]};
    end else if (i_wr && state == ST_RUN) begin
      for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
        if (i_addr == offset_step_pkg::ADDR_ACC_OFF_X + 8'(i)) begin
          next_off[i] = i_wdata;                              // R5
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
        off[i] <= offset_step_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
        off[i] <= next_off[i];
      end
    end
  end

  // ==========================================================================
  // step total and configuration
  // a step in the same cycle as a clear is dropped: clear is a restart
  always_comb begin
    next_step = step;
    next_conf = conf;
    if (cmd_wr && i_wdata == offset_step_pkg::CMD_STEP_CLR) begin
      next_step = offset_step_pkg::RST_STEP;                  // R13
    end else if (i_step) begin
      next_step = step + 16'h0001;                            // R10
    end
    if (i_wr && i_addr == offset_step_pkg::ADDR_STEP_CONF0) begin
      next_conf[7:0] = i_wdata;                               // R11 R12
    end
    if (i_wr && i_addr == offset_step_pkg::ADDR_STEP_CONF1) begin
      next_conf[15:8] = i_wdata & offset_step_pkg::MASK_CONF1_WR; // R11
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step <= offset_step_pkg::RST_STEP;
      conf <= {offset_step_pkg::RST_BYTE, offset_step_pkg::RST_BYTE};
    end else begin
      step <= next_step;
      conf <= next_conf;
    end
  end

  // ==========================================================================
  // command strobes toward nvm and foc engine
  always_comb begin
    next_store_req = cmd_wr && state == ST_RUN &&
                     i_wdata == offset_step_pkg::CMD_PROG_NVM;  // R4 R14
    next_foc_req   = cmd_wr && state == ST_RUN &&
                     i_wdata == offset_step_pkg::CMD_START_FOC; // R15
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      store_req <= 1'b0;
      foc_req   <= 1'b0;
    end else begin
      store_req <= next_store_req;
      foc_req   <= next_foc_req;
    end
  end

  // ==========================================================================
  // read mux; write-only bits and reserved bits read as zero
  always_comb begin
    next_rdata = offset_step_pkg::RST_BYTE;
    if (i_rd) begin
      for (int i = 0; i < offset_step_pkg::NUM_OFF; i++) begin
        if (i_addr == offset_step_pkg::ADDR_ACC_OFF_X + 8'(i)) begin
          next_rdata = off[i];                                // R8 R9
        end
      end
      if (i_addr == offset_step_pkg::ADDR_STEP_LO) begin
        next_rdata = step[7:0];                               // R10
      end
      if (i_addr == offset_step_pkg::ADDR_STEP_HI) begin
        next_rdata = step[15:8];                              // R10
      end
      if (i_addr == offset_step_pkg::ADDR_STEP_CONF0) begin
        next_rdata = conf[7:0] & offset_step_pkg::MASK_CONF0_RD; // R11
      end
      if (i_addr == offset_step_pkg::ADDR_STEP_CONF1) begin
        next_rdata = conf[15:8] & offset_step_pkg::MASK_CONF1_RD; // R11
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= offset_step_pkg::RST_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // compensated data: a disabled sensor passes data through untouched
  always_comb begin
    for (int a = 0; a < 6; a++) begin
      if ((a < 3) ? acc_en : gyr_en) begin
        next_filt[16*a +: 16] = i_filt_data[16*a +: 16] + offs_ext[a]; // R1
        next_pre[16*a +: 16]  = i_pre_data[16*a +: 16] + offs_ext[a];  // R1
      end else begin
        next_filt[16*a +: 16] = i_filt_data[16*a +: 16];
        next_pre[16*a +: 16]  = i_pre_data[16*a +: 16];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_q <= '0;
      pre_q  <= '0;
    end else begin
      filt_q <= next_filt;
      pre_q  <= next_pre;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rdata     = rdata;
  assign o_nvm_load  = load_req;
  assign o_nvm_store = store_req;
  assign o_foc_start = foc_req;
  assign o_step_conf = conf;
  assign o_filt_data = filt_q;
  assign o_pre_data  = pre_q;
  generate
    for (g = 0; g < offset_step_pkg::NUM_OFF; g++) begin : g_img
      assign o_nvm_data[8*g +: 8] = off[g];                   // R4
    end
  endgenerate

  // ==========================================================================
  // checks
  a_step_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cmd_wr && i_wdata == offset_step_pkg::CMD_STEP_CLR |=> step == 16'h0000)
    else $error("step total not cleared"); // R13
  a_step_count: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_step && !cmd_wr |=> step == $past(step) + 16'h0001)
    else $error("step total did not advance"); // R10
  a_step_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_step && !cmd_wr |=> $stable(step))
    else $error("step total changed without a step"); // R10
  a_store_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cmd_wr && state == ST_RUN && i_wdata == offset_step_pkg::CMD_PROG_NVM
    |=> o_nvm_store ##1 !o_nvm_store)
    else $error("nvm store strobe wrong"); // R14
  a_foc_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_foc_start |-> $past(cmd_wr) &&
    $past(i_wdata) == offset_step_pkg::CMD_START_FOC)
    else $error("foc start without command"); // R15
  a_foc_result: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_foc_done && state != ST_LOAD |=> off[3] == $past(i_foc_gyr_x[7:0])
    && off[6][1:0] == $past(i_foc_gyr_x[9:8]))
    else $error("foc result not stored"); // R5
  a_nvm_reload: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state == ST_RUN && i_soft_rst |=> ##1 o_nvm_load)
    else $error("no reload after soft reset"); // R3
  a_acc_bypass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !acc_en |=> o_filt_data[15:0] == $past(i_filt_data[15:0]))
    else $error("accel offset applied while disabled"); // R1
  a_gyro_add: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gyr_en |=> o_pre_data[63:48] == $past(i_pre_data[63:48])
    + {{6{$past(off[6][1])}}, $past(off[6][1:0]), $past(off[3])})
    else $error("gyro offset sum wrong"); // R1 R7
  a_conf_wo: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_rd && i_addr == offset_step_pkg::ADDR_STEP_CONF1 |=> o_rdata[7:4] == 4'h0)
    else $error("write-only bits visible"); // R11

  c_step_clear: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    step != 16'h0000 ##1 step == 16'h0000);
  c_foc_done: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_foc_start ##[1:50] i_foc_done);
  c_soft_reload: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_soft_rst ##[1:20] i_nvm_valid);

endmodule // offset_comp_step_count_regs

// ### pkg/offset_step_pkg.sv
// offset_step_pkg: addresses, field positions, reset values and command
// codes shared by the offset / step counter register bank.
// assumes a byte-wide register port with 8-bit addresses.
package offset_step_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_ACC_OFF_X   = 8'h71;
  localparam logic [7:0] ADDR_ACC_OFF_Y   = 8'h72;
  localparam logic [7:0] ADDR_ACC_OFF_Z   = 8'h73;
  localparam logic [7:0] ADDR_GYR_OFF_XL  = 8'h74;
  localparam logic [7:0] ADDR_GYR_OFF_YL  = 8'h75;
  localparam logic [7:0] ADDR_GYR_OFF_ZL  = 8'h76;
  localparam logic [7:0] ADDR_OFF_EN_HI   = 8'h77;
  localparam logic [7:0] ADDR_STEP_LO     = 8'h78;
  localparam logic [7:0] ADDR_STEP_HI     = 8'h79;
  localparam logic [7:0] ADDR_STEP_CONF0  = 8'h7a;
  localparam logic [7:0] ADDR_STEP_CONF1  = 8'h7b;
  localparam logic [7:0] ADDR_CMD         = 8'h7e;

  // ==========================================================================
  // field positions of the enables / gyro high byte and the step config write-only bit
  localparam int BIT_GYR_EN     = 7;
  localparam int BIT_ACC_EN     = 6;
  localparam int POS_GYR_Z_HI   = 4;
  localparam int POS_GYR_Y_HI   = 2;
  localparam int POS_GYR_X_HI   = 0;
  localparam int BIT_CONF_WO    = 7;
  // readable masks of the step configuration bytes, writable mask of byte 1
  localparam logic [7:0] MASK_CONF0_RD = 8'h7f;
  localparam logic [7:0] MASK_CONF1_RD = 8'h0f;
  localparam logic [7:0] MASK_CONF1_WR = 8'h8f;

  // ==========================================================================
  // widths
  localparam int ACC_OFF_W  = 8;
  localparam int GYR_OFF_W  = 10;
  localparam int DATA_W     = 16;
  localparam int STEP_W     = 16;
  localparam int NUM_OFF    = 7;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_STEP = 16'h0000;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_START_FOC = 8'h03;
  localparam logic [7:0] CMD_PROG_NVM  = 8'ha0;
  localparam logic [7:0] CMD_STEP_CLR  = 8'hb2;
  localparam logic [7:0] CMD_SOFTRESET = 8'hb6;

endpackage

// ### tb/test_offset_comp_step_count_regs.sv
// test_offset_comp_step_count_regs: self-checking bench for the offset,
// step total and step configuration register bank.
// assumes the design and offset_step_pkg are compiled first.
`timescale 1ns/1ps
module test_offset_comp_step_count_regs;
  // ==========================================================================
  // stimulus and observation signals
  logic        i_mclk      = 1'b0;  // 250 MHz clock
  logic        i_rst_n     = 1'b0;  // async reset, low active
  logic        i_wr        = 1'b0;  // byte write strobe
  logic        i_rd        = 1'b0;  // byte read strobe
  logic [7:0]  i_addr      = 8'h00; // byte address
  logic [7:0]  i_wdata     = 8'h00; // write data
  logic        i_soft_rst  = 1'b0;  // soft reset pulse
  logic [55:0] i_nvm_data  = 56'hc5665544332211; // stored image
  logic        i_nvm_valid = 1'b0;  // image valid pulse
  logic        i_foc_done  = 1'b0;  // calibration done pulse
  logic        i_step      = 1'b0;  // step pulse
  logic [9:0]  i_foc_gyr_z = 10'h0aa; // calibration gyro z result
  logic [95:0] i_filt_data = 96'h0; // filtered data in
  logic [95:0] i_pre_data  = 96'h0; // pre-filtered data in
  logic [7:0]  o_rdata;             // read data
  logic        o_nvm_load;          // load request
  logic        o_nvm_store;         // store pulse
  logic [55:0] o_nvm_data;          // live offset image
  logic        o_foc_start;         // calibration start pulse
  logic [15:0] o_step_conf;         // step configuration
  logic [95:0] o_filt_data;         // filtered data out
  logic [95:0] o_pre_data;          // pre-filtered data out
  int          failures    = 0;     // mismatch count
  int          checks      = 0;     // comparison count
  logic [7:0]  ofs [7];             // tb copy of the offset bytes
  logic [7:0]  rv;                  // scratch read value
  int          n;                   // scratch pulse count
  // row: address, written byte, expected read back
  logic [23:0] rows [19] = '{24'h718080, 24'h727f7f, 24'h730101,
    24'h740000, 24'h75ffff, 24'h761010, 24'h77c6c6, 24'h7aff7f,
    24'h7bff0f, 24'h7a1515, 24'h7b0303, 24'h7a2d2d, 24'h7b0000,
    24'h7a1d1d, 24'h7b0707, 24'h705500, 24'h78ff00, 24'h79ff00,
    24'h7f3300};

  always #2 i_mclk = ~i_mclk;

  offset_comp_step_count_regs uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_soft_rst(i_soft_rst), .i_nvm_data(i_nvm_data),
    .i_nvm_valid(i_nvm_valid), .o_nvm_load(o_nvm_load),
    .o_nvm_store(o_nvm_store), .o_nvm_data(o_nvm_data),
    .o_foc_start(o_foc_start), .i_foc_done(i_foc_done),
    .i_foc_acc_x(8'h05), .i_foc_acc_y(8'hfb), .i_foc_acc_z(8'h00),
    .i_foc_gyr_x(10'h3ff), .i_foc_gyr_y(10'h155),
    .i_foc_gyr_z(i_foc_gyr_z),
    .i_step(i_step), .o_step_conf(o_step_conf),
    .i_filt_data(i_filt_data), .i_pre_data(i_pre_data),
    .o_filt_data(o_filt_data), .o_pre_data(o_pre_data));

  // ==========================================================================
  // bus tasks, all driving on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_wr    = 1'b1;
    i_addr  = a;
    i_wdata = d;
    @(negedge i_mclk);
    i_wr = 1'b0;
  endtask
  // read data is registered, so it is settled at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    i_rd   = 1'b1;
    i_addr = a;
    @(negedge i_mclk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask
  // ==========================================================================
  // compare tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t vector got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk_byte(rv, exp);
  endtask
  // count one-cycle pulses of store (sel 0) or calibration start (sel 1)
  // first look is at once: the strobe already stands when wr returns
  task automatic pulses(input int sel, output int cnt);
    cnt = 0;
    repeat (4) begin
      if ((sel == 0) ? (o_nvm_store === 1'b1) : (o_foc_start === 1'b1))
        cnt++;
      @(negedge i_mclk);
    end
  endtask
  // wait for the load request under a bound, then hand over the image
  task automatic nvm_answer();
    n = 0;
    while (o_nvm_load !== 1'b1 && n < 10) begin
      @(negedge i_mclk);
      n++;
    end
    chk_cnt(int'(o_nvm_load === 1'b1), 1);
    i_nvm_valid = 1'b1;
    @(negedge i_mclk);
    i_nvm_valid = 1'b0;
    @(negedge i_mclk);
  endtask
  // expected data path output from the tb offset copy, signed extension
  function automatic logic [95:0] exp_data(logic [95:0] d, logic [7:0] e);
    logic [15:0] o;
    for (int i = 0; i < 6; i++) begin
      if (i < 3)
        o = e[6] ? {{8{ofs[i][7]}}, ofs[i]} : 16'h0000;
      else
        o = e[7] ? {{6{e[2*(i-3)+1]}}, e[2*(i-3)+:2], ofs[i]} : 16'h0000;
      exp_data[16*i+:16] = d[16*i+:16] + o;
    end
  endfunction
  task automatic summarize();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // watchdog: whole run needs about 700 cycles
  initial begin
    #(5000 * 4);
    failures++;
    summarize();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(negedge i_mclk);
    chk_byte(o_rdata, 8'h00);
    chk_cnt(int'(o_nvm_load === 1'b1), 0);
    i_rst_n = 1'b1;
    rd_chk(8'h78, 8'h00);
    nvm_answer();
    for (int i = 0; i < 7; i++)
      rd_chk(8'h71 + 8'(i), i_nvm_data[8*i+:8]);
    // mapped, unmapped and read-only addresses: write then read back
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd_chk(rows[i][23:16], rows[i][7:0]);
      if (rows[i][23:16] >= 8'h71 && rows[i][23:16] < 8'h78)
        ofs[rows[i][23:16] - 8'h71] = rows[i][15:8];
    end
    chk_vec(96'(o_step_conf), 96'(16'h071d));
    chk_vec(96'(o_nvm_data), 96'h00c610ff00017f80);
    // data path under every enable combination
    i_filt_data = 96'h8000_7ff0_0100_fff0_0010_1000;
    i_pre_data  = 96'h0001_0200_ffff_0030_8000_7fff;
    for (int k = 0; k < 4; k++) begin
      wr(8'h77, {k[1:0], 6'h06});
      ofs[6] = {k[1:0], 6'h06};
      repeat (2) @(negedge i_mclk);
      chk_vec(o_filt_data, exp_data(i_filt_data, ofs[6]));
      chk_vec(o_pre_data, exp_data(i_pre_data, ofs[6]));
    end
    // store command gives one store pulse
    wr(8'h7e, 8'ha0);
    pulses(0, n);
    chk_cnt(n, 1);
    // calibration overwrites offsets, enables stay
    wr(8'h7e, 8'h03);
    pulses(1, n);
    chk_cnt(n, 1);
    i_foc_done = 1'b1;
    @(negedge i_mclk);
    i_foc_done = 1'b0;
    rd_chk(8'h71, 8'h05);
    rd_chk(8'h72, 8'hfb);
    rd_chk(8'h74, 8'hff);
    rd_chk(8'h76, 8'haa);
    rd_chk(8'h77, 8'hc7);
    // step total crosses into the high byte, then is cleared
    repeat (260) begin
      @(negedge i_mclk);
      i_step = 1'b1;
      @(negedge i_mclk);
      i_step = 1'b0;
    end
    rd_chk(8'h78, 8'h04);
    rd_chk(8'h79, 8'h01);
    wr(8'h7e, 8'hb2);
    rd_chk(8'h78, 8'h00);
    rd_chk(8'h79, 8'h00);
    // one step after the clear proves the count restarted from zero
    @(negedge i_mclk);
    i_step = 1'b1;
    @(negedge i_mclk);
    i_step = 1'b0;
    rd_chk(8'h78, 8'h01);
    // soft reset reloads the stored image
    @(negedge i_mclk);
    i_soft_rst = 1'b1;
    @(negedge i_mclk);
    i_soft_rst = 1'b0;
    // calibration command while loading is refused
    wr(8'h7e, 8'h03);
    pulses(1, n);
    chk_cnt(n, 0);
    nvm_answer();
    rd_chk(8'h71, 8'h11);
    rd_chk(8'h77, 8'hc5);
    summarize();
  end
endmodule // test_offset_comp_step_count_regs
